/* verilog/upc_pkg.sv */
// Package for the upconverter profile bank: register map, field
// positions, reset values and update sequencer states.
// Assumes a 32-bit classic Wishbone slave port and a single clock.
`default_nettype none

package upc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] UPC_OFF_CTRL       = 8'h00;
  localparam logic [7:0] UPC_OFF_FTW        = 8'h04;
  localparam logic [7:0] UPC_OFF_PHASE_ASF  = 8'h08;
  localparam logic [7:0] UPC_OFF_FILTER     = 8'h0c;
  localparam logic [7:0] UPC_OFF_STATUS     = 8'h10;
  localparam logic [7:0] UPC_OFF_ACTIVE_FTW = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int UPC_CTRL_UPDATE_BIT = 0;
  localparam int UPC_CTRL_SEL_LSB    = 4;
  localparam int UPC_CTRL_STAGE_LSB  = 8;
  localparam int UPC_PA_PHASE_LSB    = 0;
  localparam int UPC_PA_ASF_LSB      = 16;
  localparam int UPC_FLT_RATE_LSB    = 0;
  localparam int UPC_FLT_BYPASS_BIT  = 8;
  localparam int UPC_FLT_INVERT_BIT  = 9;
  localparam int UPC_ST_ACTIVE_LSB   = 0;
  localparam int UPC_ST_BUSY_BIT     = 3;
  localparam int UPC_ST_DIRTY_BIT    = 4;
  localparam int UPC_ST_RATE_LSB     = 8;
  localparam int UPC_ST_BYPASS_BIT   = 16;
  localparam int UPC_ST_INVERT_BIT   = 17;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int UPC_PROFILES = 8;
  localparam int UPC_PROF_W   = 64;
  localparam logic [31:0] UPC_RST_FTW    = 32'h0000_0000;
  localparam logic [15:0] UPC_RST_PHASE  = 16'h0000;
  localparam logic [7:0]  UPC_RST_ASF    = 8'h00;
  localparam logic [5:0]  UPC_RST_RATE   = 6'h01;
  localparam logic [2:0]  UPC_RST_SEL    = 3'h0;

  // Scale factor is 1.7 fixed point, so 8'h80 is unity gain.
  localparam int UPC_ASF_FRAC = 7;

  // ----------------------------------------------------------------
  // Update sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    UPC_IDLE  = 4'b0001,
    UPC_WRITE = 4'b0010,
    UPC_READ  = 4'b0100,
    UPC_LOAD  = 4'b1000
  } upc_state_t;

endpackage : upc_pkg

`default_nettype wire

/* verilog/upc_profile_mem.sv */
// Eight-entry profile store with one write port and a registered read.
// Assumes the caller never needs read data in the cycle it presents
// the address.
`default_nettype none

module upc_profile_mem (
  input  wire logic                          clock_i,
  input  wire logic                          arst_n_i,
  input  wire logic                          we_i,
  input  wire logic [2:0]                    waddr_i,
  input  wire logic [upc_pkg::UPC_PROF_W-1:0] wdata_i,
  input  wire logic [2:0]                    raddr_i,
  output logic      [upc_pkg::UPC_PROF_W-1:0] rdata_o
);
  import upc_pkg::*;

  logic [UPC_PROF_W-1:0] mem_reg [UPC_PROFILES];

  // Cleared at reset so an unwritten profile reads as all zero.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int k = 0; k < UPC_PROFILES; k++) begin
        mem_reg[k] <= '0;
      end
      rdata_o <= '0;
    end else begin
      if (we_i) begin
        mem_reg[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_reg[raddr_i];
    end
  end

endmodule : upc_profile_mem

`default_nettype wire

/* verilog/upc_profile_bank.sv */
// Profile bank and modulation datapath of the quadrature upconverter.
// Assumes a classic Wishbone master on the same clock and baseband
// samples from logic on the same clock; the update pin is external.
//
// Summary of operation
// - Carrier at active frequency, baseband upconverted onto it.
// - Sixteen-bit phase offset spans full circle.
// - Eight-bit scale factor sets carrier amplitude.
// - Comb-integrator interpolates by rate one to 63.
// - Bypass bit removes compensating filter.
// - Compensator predistorts against comb passband droop.
// - Inversion bit flips spectrum around carrier.
// - Staged writes become active only at update.
`default_nettype none

module upc_profile_bank (
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        io_update_i,
  input  wire logic [15:0] bb_i_i,
  input  wire logic [15:0] bb_q_i,
  input  wire logic        bb_valid_i,
  output logic             bb_ready_o,
  output logic      [15:0] dac_data_o,
  output logic      [2:0]  active_profile_o
);
  import upc_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Merge write data into a register under the byte enables.
  function automatic logic [31:0] upc_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction : upc_merge

  // Quarter sine, k from 0 to 16 of a 64-step circle, peak 127.
  function automatic logic [7:0] upc_quarter(input logic [4:0] k);
    logic [7:0] t;
    t = 8'h00;
    unique case (k)
      5'h00: t = 8'h00;  5'h01: t = 8'h0c;  5'h02: t = 8'h19;
      5'h03: t = 8'h25;  5'h04: t = 8'h31;  5'h05: t = 8'h3c;
      5'h06: t = 8'h47;  5'h07: t = 8'h51;  5'h08: t = 8'h5a;
      5'h09: t = 8'h62;  5'h0a: t = 8'h6a;  5'h0b: t = 8'h70;
      5'h0c: t = 8'h75;  5'h0d: t = 8'h7a;  5'h0e: t = 8'h7d;
      default: t = 8'h7f;
    endcase
    return t;
  endfunction : upc_quarter

  // Signed sine of a 6-bit phase index, built from quarter symmetry.
  function automatic logic signed [7:0] upc_sine(input logic [5:0] p);
    logic [7:0] m;
    m = p[4] ? upc_quarter(5'h10 - {1'b0, p[3:0]})
             : upc_quarter({1'b0, p[3:0]});
    return p[5] ? -$signed(m) : $signed(m);
  endfunction : upc_sine

  // ----------------------------------------------------------------
  // Wishbone slave and staging registers
  // ----------------------------------------------------------------
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic [31:0] stg_ftw_reg;
  logic [31:0] stg_pa_reg;
  logic [31:0] stg_flt_reg;
  logic [2:0]  sel_reg;
  logic [2:0]  stage_idx_reg;
  logic        dirty_reg;
  logic        upd_pend_reg;
  upc_state_t  state_reg;

  wire         req     = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire         wr      = req & wb_we_i;
  wire         wr_ctrl = wr & (wb_adr_i == UPC_OFF_CTRL);
  wire         wr_ftw  = wr & (wb_adr_i == UPC_OFF_FTW);
  wire         wr_pa   = wr & (wb_adr_i == UPC_OFF_PHASE_ASF);
  wire         wr_flt  = wr & (wb_adr_i == UPC_OFF_FILTER);
  wire         wr_stg  = wr_ftw | wr_pa | wr_flt;
  wire         upd_sw  = wr_ctrl & wb_sel_i[0] &
                         wb_dat_i[UPC_CTRL_UPDATE_BIT];
  wire [31:0]  ctrl_v  = upc_merge({21'h0, stage_idx_reg, 1'b0, sel_reg,
                                    4'h0}, wb_dat_i, wb_sel_i);

  logic [31:0] act_ftw_reg;
  logic [15:0] act_phase_reg;
  logic [7:0]  act_asf_reg;
  logic [5:0]  act_rate_reg;
  logic        act_bypass_reg;
  logic        act_invert_reg;
  logic [2:0]  act_prof_reg;

  wire [31:0]  status_v = {14'h0, act_invert_reg, act_bypass_reg, 2'h0,
                           act_rate_reg, 3'h0, dirty_reg,
                           ~(state_reg == UPC_IDLE), act_prof_reg};

  // Read mux; unmapped offsets read as zero and still acknowledge.
  wire [31:0]  rd_mux =
    (wb_adr_i == UPC_OFF_CTRL)       ? {21'h0, stage_idx_reg, 1'b0,
                                        sel_reg, 4'h0} :
    (wb_adr_i == UPC_OFF_FTW)        ? stg_ftw_reg :
    (wb_adr_i == UPC_OFF_PHASE_ASF)  ? stg_pa_reg :
    (wb_adr_i == UPC_OFF_FILTER)     ? stg_flt_reg :
    (wb_adr_i == UPC_OFF_STATUS)     ? status_v :
    (wb_adr_i == UPC_OFF_ACTIVE_FTW) ? act_ftw_reg : 32'h0;

  // One wait state: ack rises the cycle after the strobe, then drops.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ack_reg  <= req;
      rdat_reg <= req ? rd_mux : 32'h0;
    end
  end

  // Staging buffer; software writes never touch the active set.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stg_ftw_reg   <= UPC_RST_FTW;
      stg_pa_reg    <= 32'h0;
      stg_flt_reg   <= {26'h0, UPC_RST_RATE};
      sel_reg       <= UPC_RST_SEL;
      stage_idx_reg <= 3'h0;
    end else begin
      if (wr_ftw) stg_ftw_reg <= upc_merge(stg_ftw_reg, wb_dat_i, wb_sel_i);
      if (wr_pa)  stg_pa_reg  <= upc_merge(stg_pa_reg, wb_dat_i, wb_sel_i)
                                 & 32'h00ff_ffff;
      if (wr_flt) stg_flt_reg <= upc_merge(stg_flt_reg, wb_dat_i, wb_sel_i)
                                 & 32'h0000_033f;
      if (wr_ctrl) begin
        sel_reg       <= ctrl_v[UPC_CTRL_SEL_LSB +: 3];
        stage_idx_reg <= ctrl_v[UPC_CTRL_STAGE_LSB +: 3];
      end
    end
  end

  assign wb_dat_o = rdat_reg;
  assign wb_ack_o = ack_reg;

  // ----------------------------------------------------------------
  // Update pin synchroniser and update sequencer
  // ----------------------------------------------------------------
  logic [2:0] pin_sync_reg;
  logic       pin_level_reg;
  wire        pin_agree = pin_sync_reg[1] == pin_sync_reg[2];
  wire        pin_rise  = pin_agree & pin_sync_reg[2] & ~pin_level_reg;
  wire        upd_req   = upd_sw | pin_rise;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_sync_reg  <= 3'h0;
      pin_level_reg <= 1'b0;
    end else begin
      pin_sync_reg  <= {pin_sync_reg[1:0], io_update_i};
      if (pin_agree) pin_level_reg <= pin_sync_reg[2];
    end
  end

  wire [UPC_PROF_W-1:0] mem_rdata;
  wire                  mem_we   = state_reg == UPC_WRITE & dirty_reg;
  // Packed as ftw, phase, scale, bypass, invert, rate to match the load.
  wire [UPC_PROF_W-1:0] mem_wdata = {stg_ftw_reg, stg_pa_reg[15:0],
                                     stg_pa_reg[23:16],
                                     stg_flt_reg[UPC_FLT_BYPASS_BIT],
                                     stg_flt_reg[UPC_FLT_INVERT_BIT],
                                     stg_flt_reg[5:0]};
  logic [2:0]           pend_sel_reg;
  upc_state_t           state_next;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      UPC_IDLE:  if (upd_pend_reg) state_next = UPC_WRITE;
      UPC_WRITE: state_next = UPC_READ;
      UPC_READ:  state_next = UPC_LOAD;
      UPC_LOAD:  state_next = UPC_IDLE;
      default:   state_next = UPC_IDLE;
    endcase
  end

  // A request or staging write in the clearing cycle wins over the clear.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg    <= UPC_IDLE;
      upd_pend_reg <= 1'b0;
      dirty_reg    <= 1'b0;
      pend_sel_reg <= UPC_RST_SEL;
    end else begin
      state_reg    <= state_next;
      upd_pend_reg <= upd_req | (upd_pend_reg & ~(state_reg == UPC_IDLE));
      dirty_reg    <= wr_stg | (dirty_reg & ~(state_reg == UPC_WRITE));
      if (state_reg == UPC_IDLE & upd_pend_reg) pend_sel_reg <= sel_reg;
    end
  end

  upc_profile_mem u_mem (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .we_i     (mem_we),
    .waddr_i  (stage_idx_reg),
    .wdata_i  (mem_wdata),
    .raddr_i  (pend_sel_reg),
    .rdata_o  (mem_rdata)
  );

  // Active set loads as one unit so all words change in the same cycle.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      act_ftw_reg    <= UPC_RST_FTW;
      act_phase_reg  <= UPC_RST_PHASE;
      act_asf_reg    <= UPC_RST_ASF;
      act_rate_reg   <= UPC_RST_RATE;
      act_bypass_reg <= 1'b0;
      act_invert_reg <= 1'b0;
      act_prof_reg   <= UPC_RST_SEL;
    end else if (state_reg == UPC_LOAD) begin
      {act_ftw_reg, act_phase_reg, act_asf_reg} <= mem_rdata[63:8];
      act_bypass_reg <= mem_rdata[7];
      act_invert_reg <= mem_rdata[6];
      act_rate_reg   <= mem_rdata[5:0];
      act_prof_reg   <= pend_sel_reg;
    end
  end

  assign active_profile_o = act_prof_reg;

  // ----------------------------------------------------------------
  // Interpolation, compensation and mixing
  // ----------------------------------------------------------------
  logic [5:0]         icnt_reg;
  logic               rdy_reg;
  logic signed [15:0] ti_reg [2];
  logic signed [15:0] tq_reg [2];
  logic signed [17:0] ci_reg, cq_reg, pi_reg, pq_reg;
  logic [31:0]        acc_reg;
  logic signed [26:0] mix_reg;
  logic [15:0]        dac_reg;

  // Rate zero is treated as one, so the block never stalls outright.
  wire [5:0] rate_m1 = (act_rate_reg == 6'h0) ? 6'h0 : act_rate_reg - 6'h1;
  wire       tick    = rdy_reg;
  wire signed [15:0] xi = bb_valid_i ? $signed(bb_i_i) : 16'sh0;
  wire signed [15:0] xq = bb_valid_i ? $signed(bb_q_i) : 16'sh0;

  // Three-tap lift of the upper band: x + (2x - x1 - x2) / 16.
  wire signed [17:0] di = (18'(xi) <<< 1) - 18'(ti_reg[0]) - 18'(ti_reg[1]);
  wire signed [17:0] dq = (18'(xq) <<< 1) - 18'(tq_reg[0]) - 18'(tq_reg[1]);
  wire signed [17:0] pre_i = act_bypass_reg ? 18'(xi)
                                            : 18'(xi) + (di >>> 4);
  wire signed [17:0] pre_q = act_bypass_reg ? 18'(xq) : 18'(xq) + (dq >>> 4);

  // First-order comb and integrator both update on the input tick, so output holds between samples.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      icnt_reg <= 6'h0;
      rdy_reg  <= 1'b1;
      ti_reg   <= '{default: 16'sh0};
      tq_reg   <= '{default: 16'sh0};
      pi_reg   <= 18'sh0;
      pq_reg   <= 18'sh0;
      ci_reg   <= 18'sh0;
      cq_reg   <= 18'sh0;
    end else begin
      icnt_reg <= (icnt_reg >= rate_m1) ? 6'h0 : icnt_reg + 6'h1;
      rdy_reg  <= (icnt_reg >= rate_m1) ? (rate_m1 == 6'h0) | ~rdy_reg
                                        : (icnt_reg + 6'h1 >= rate_m1);
      if (tick) begin
        ti_reg <= '{xi, ti_reg[0]};
        tq_reg <= '{xq, tq_reg[0]};
        pi_reg <= pre_i;
        pq_reg <= pre_q;
        ci_reg <= ci_reg + (pre_i - pi_reg);
        cq_reg <= cq_reg + (pre_q - pq_reg);
      end
    end
  end

  assign bb_ready_o = rdy_reg;

  wire [15:0] phase_word = 16'(acc_reg[31:16] + act_phase_reg);
  wire signed [7:0] sin_v = upc_sine(phase_word[15:10]);
  wire signed [7:0] cos_v = upc_sine(phase_word[15:10] + 6'h10);
  wire signed [17:0] q_use = act_invert_reg ? -cq_reg : cq_reg;
  wire signed [26:0] mix_v = 27'(ci_reg * cos_v) - 27'(q_use * sin_v);
  wire signed [19:0] mix_s = 20'(mix_reg >>> UPC_ASF_FRAC);
  wire signed [28:0] scl_v = 29'(mix_s * $signed({1'b0, act_asf_reg}));
  wire signed [21:0] scl_s = 22'(scl_v >>> UPC_ASF_FRAC);
  wire [15:0] sat_v = (scl_s > 22'sh7fff)  ? 16'h7fff :
                      (scl_s < -22'sh8000) ? 16'h8000 : scl_s[15:0];

  // Two pipeline stages: mixing, then amplitude scaling and clamping.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_reg <= 32'h0;
      mix_reg <= 27'sh0;
      dac_reg <= 16'h0;
    end else begin
      acc_reg <= acc_reg + act_ftw_reg;
      mix_reg <= mix_v;
      dac_reg <= sat_v;
    end
  end

  assign dac_data_o = dac_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  AST_ACC_STEP: assert property (
    acc_reg == $past(acc_reg) + $past(act_ftw_reg))
    else $error("Phase accumulator did not step by the tuning word.");
  AST_PHASE_OFS: assert property (
    phase_word == 16'(acc_reg[31:16] + act_phase_reg))
    else $error("Phase offset not added to carrier phase.");
  AST_ASF_ZERO: assert property (
    (act_asf_reg == 8'h0) [*2] |=> dac_data_o == 16'h0)
    else $error("Zero scale factor did not silence output.");
  AST_RATE3: assert property (
    rdy_reg && act_rate_reg == 6'h3 && state_reg == UPC_IDLE
    && $past(act_rate_reg) == 6'h3 && $past(act_rate_reg, 2) == 6'h3
    |=> !rdy_reg ##1 !rdy_reg ##1 rdy_reg)
    else $error("Input strobe spacing wrong for rate three.");
  AST_BYPASS: assert property (
    act_bypass_reg |-> pre_i == 18'(xi))
    else $error("Bypass did not pass data unchanged.");
  AST_COMP_FLAT: assert property (
    !act_bypass_reg && xi == ti_reg[0] && xi == ti_reg[1] |-> pre_i == 18'(xi))
    else $error("Compensator altered a flat signal.");
  AST_INVERT: assert property (
    act_invert_reg |-> q_use == -cq_reg)
    else $error("Spectral inversion did not negate quadrature.");
  AST_UPD_SEQ: assert property (
    state_reg == UPC_IDLE && upd_pend_reg
    |=> state_reg == UPC_WRITE ##1 state_reg == UPC_READ
    ##1 state_reg == UPC_LOAD)
    else $error("Update sequence out of order.");
  AST_HOLD: assert property (
    $changed(act_ftw_reg) |-> $past(state_reg) == UPC_LOAD)
    else $error("Active tuning word changed outside an update.");
  AST_ONE_ACTIVE: assert property (
    $past(state_reg) == UPC_LOAD |-> act_prof_reg == $past(pend_sel_reg))
    else $error("Active profile differs from requested one.");

  COV_UPDATE: cover property (state_reg == UPC_WRITE && dirty_reg);
  COV_PIN:    cover property (pin_rise);
  COV_INVERT: cover property (act_invert_reg && tick && bb_valid_i);
  COV_SAT:    cover property (scl_s > 22'sh7fff);

endmodule : upc_profile_bank

`default_nettype wire

/* bench/upconverter_profile_params_tb.sv */
// Self-checking bench for the upconverter profile bank.
// Assumes the bank acks each Wishbone request one cycle after it.
`default_nettype none

module upconverter_profile_params_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import upc_pkg::*;

  // --------------------------------------------------------------
  // Signals and expected profile contents
  // --------------------------------------------------------------
  logic        clock_i, arst_n_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        wb_ack_o, io_update_i, bb_valid_i, bb_ready_o, fix_bb;
  logic [15:0] bb_i_i, bb_q_i, dac_data_o;
  logic [2:0]  active_profile_o;
  logic [31:0] ftw [8];
  logic [31:0] pa  [8];
  logic [31:0] flt [8];
  logic signed [16:0] d1, d2;
  int          seed, n_mismatch, cmp_count, hit;

  upc_profile_bank uut (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .io_update_i(io_update_i), .bb_i_i(bb_i_i),
    .bb_q_i(bb_q_i), .bb_valid_i(bb_valid_i), .bb_ready_o(bb_ready_o),
    .dac_data_o(dac_data_o), .active_profile_o(active_profile_o));

  // Free-running 250 MHz clock.
  always #2 clock_i = ~clock_i;

  // Random baseband; the fixed mode holds a pure Q input.
  always @(posedge clock_i) begin
    bb_i_i     <= fix_bb ? 16'h0000 : 16'($random(seed));
    bb_q_i     <= fix_bb ? 16'h4000 : 16'($random(seed));
    bb_valid_i <= fix_bb | 1'($random(seed));
  end

  // --------------------------------------------------------------
  // Bus cycle, comparisons and expectations
  // --------------------------------------------------------------
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [3:0] s, input logic [31:0] d);
    @(posedge clock_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    // Only the watchdog ends a wait for the acknowledge.
    do begin
      @(posedge clock_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic chk_reg(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg

  task automatic chk_flag(input string nm, input logic ok);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %s expected 1 seen %b", nm, ok);
    end
  endtask : chk_flag

  // Status word of a profile once it is active and the bank is idle.
  function automatic logic [31:0] exp_st(input int k);
    return {14'h0, flt[k][9], flt[k][8], 2'b00, flt[k][5:0], 5'h00,
            3'(k)};
  endfunction : exp_st

  // Control write: stage and select profile k, optional trigger.
  task automatic ctrl(input int k, input logic upd);
    wb(1'b1, UPC_OFF_CTRL, 4'hf,
       {21'h0, 3'(k), 1'b0, 3'(k), 3'b000, upd});
  endtask : ctrl

  // Check of an active profile: status, tuning word, profile number and strobe spacing.
  task automatic verify(input int k);
    int g;
    wb(1'b0, UPC_OFF_STATUS, 4'hf, 32'h0);
    chk_reg("status", exp_st(k), rd);
    wb(1'b0, UPC_OFF_ACTIVE_FTW, 4'hf, 32'h0);
    chk_reg("active_ftw", ftw[k], rd);
    chk_reg("active_prof", 32'(k), 32'(active_profile_o));
    for (int j = 0; j < 2; j++) begin
      g = 0;
      do begin
        @(posedge clock_i);
        g++;
      end while (bb_ready_o !== 1'b1 && g < 200);
    end
    chk_reg("ready_gap", 32'(flt[k][5:0]), 32'(g));
  endtask : verify

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // Whole run is a few thousand cycles; this limit catches a hang.
  initial begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    complete_run();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    seed = 32'h96cc;
    {clock_i, arst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, io_update_i} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, bb_i_i, bb_q_i} = '0;
    {bb_valid_i, fix_bb, n_mismatch, cmp_count} = '0;
    repeat (8) @(posedge clock_i);
    arst_n_i <= 1'b1;
    wb(1'b0, UPC_OFF_STATUS, 4'hf, 32'h0);
    chk_reg("status_rst", 32'h0000_0100, rd);
    wb(1'b0, 8'h3c, 4'hf, 32'h0);
    chk_reg("unmapped", 32'h0, rd);
    $display("reset test done");
    // Load every profile with random values and boundary rates.
    for (int k = 0; k < 8; k++) begin
      ftw[k] = $random(seed);
      pa[k]  = {8'h0, (k == 3) ? 8'h00 : 8'($random(seed)),
                16'($random(seed))};
      if (k == 4) pa[k][23:16] = 8'h80;
      flt[k] = {22'h0, 2'($random(seed)), 2'b00, 6'($random(seed))};
      if (flt[k][5:0] == 6'h0 || k == 6) flt[k][5:0] = 6'h01;
      if (k == 5) flt[k][5:0] = 6'h3f;
      if (k == 2) flt[k][5:0] = 6'h03;
      ctrl(k, 1'b0);
      wb(1'b1, UPC_OFF_FTW, 4'hf, ftw[k]);
      wb(1'b1, UPC_OFF_PHASE_ASF, 4'hf, pa[k]);
      wb(1'b1, UPC_OFF_FILTER, 4'hf, flt[k]);
      wb(1'b0, UPC_OFF_PHASE_ASF, 4'hf, 32'h0);
      chk_reg("phase_asf", pa[k], rd);
      wb(1'b0, UPC_OFF_FILTER, 4'hf, 32'h0);
      chk_reg("filter", flt[k], rd);
      wb(1'b0, UPC_OFF_ACTIVE_FTW, 4'hf, 32'h0);
      chk_reg("ftw_held", (k == 0) ? 32'h0 : ftw[k - 1], rd);
      ctrl(k, 1'b1);
      @(posedge clock_i);
      chk_reg("prof_held", 32'((k == 0) ? 0 : k - 1),
              32'(active_profile_o));
      repeat (6) @(posedge clock_i);
      verify(k);
      hit = 0;
      for (int c = 0; c < 64; c++) begin
        @(posedge clock_i);
        if (k == 3) chk_reg("dac_mute", 32'h0, 32'(dac_data_o));
        if (dac_data_o !== 16'h0) hit++;
      end
      if (k == 4) chk_flag("dac_live", hit > 0);
    end
    $display("load test done");
    // Reselect stored profiles through the update pin.
    for (int j = 7; j >= 0; j--) begin
      ctrl(j, 1'b0);
      io_update_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      io_update_i <= 1'b0;
      repeat (12) @(posedge clock_i);
      verify(j);
    end
    $display("reselect test done");
    // Byte lanes, read-only status and the staging dirty flag.
    wb(1'b1, UPC_OFF_FTW, 4'hf, 32'h1234_5678);
    wb(1'b1, UPC_OFF_FTW, 4'h4, 32'hffff_ffff);
    wb(1'b0, UPC_OFF_FTW, 4'hf, 32'h0);
    chk_reg("ftw_lane", 32'h12ff_5678, rd);
    wb(1'b1, UPC_OFF_STATUS, 4'hf, 32'hffff_ffff);
    wb(1'b0, UPC_OFF_STATUS, 4'hf, 32'h0);
    chk_reg("status_ro", exp_st(0) | 32'h10, rd);
    $display("lane test done");
    // Same static tone with and without inversion: sign must flip.
    fix_bb = 1'b1;
    for (int v = 0; v < 2; v++) begin
      ctrl(6 + v, 1'b0);
      wb(1'b1, UPC_OFF_FTW, 4'hf, 32'h0);
      wb(1'b1, UPC_OFF_PHASE_ASF, 4'hf, 32'h0080_4000);
      wb(1'b1, UPC_OFF_FILTER, 4'hf, {22'h0, v[0], 1'b1, 8'h01});
      ctrl(6 + v, 1'b1);
      repeat (16) @(posedge clock_i);
      if (v == 0) d1 = 17'(signed'(dac_data_o));
      else d2 = 17'(signed'(dac_data_o));
    end
    chk_flag("invert", (d1 + d2 <= 2) && (d1 + d2 >= -2));
    $display("inversion test done");
    complete_run();
  end

endmodule : upconverter_profile_params_tb

`default_nettype wire
